//--- verification/tb.sv
// testbench: ownership walk and alternate-master trials
`default_nettype none
module tb
  import twbo_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk, rst, watchdog_reset, bus_grant_in_n, bus_lock_bit, core_bus_need;
  logic core_cycle_active, core_cycle_end, core_burst_inhibit_more, transfer_start_in_n;
  logic [TWBO_AW-1:0] addr_in, am_addr;
  logic read_in, top_addr_pins_are_addr, dram_addr_drive_en, default_auto_ack;
  logic [1:0] xfer_width_code_in;
  twbo_cs_s [TWBO_NCS-1:0] cs_cfg;
  twbo_dram_s [TWBO_NRAS-1:0] dram_cfg;
  logic [TWBO_WSW-1:0] default_wait_states;
  twbo_own_e own_state;
  logic bus_driven_out_n, bus_request_out_n, bus_drive_oe_n, dram_addr_oe_n;
  logic transfer_ack_out_n, transfer_ack_oe_n, dram_write_n, core_may_start;
  logic [TWBO_NCS-1:0] chip_sel_n;
  logic [TWBO_NWE-1:0] write_en_n;
  logic [TWBO_NRAS-1:0] row_strobe_n;
  logic [TWBO_NCAS-1:0] col_strobe_n;
  logic grant_want, am_go, am_read, am_busy;
  int n_mismatch, checked, cyc;
  twbo_arbiter i_twbo_arbiter (.mclk, .rst, .watchdog_reset, .bus_grant_in_n, .bus_lock_bit,
    .core_bus_need, .core_cycle_active, .core_cycle_end, .core_burst_inhibit_more,
    .transfer_start_in_n, .addr_in, .read_in, .xfer_width_code_in, .top_addr_pins_are_addr,
    .cs_cfg, .dram_cfg, .dram_addr_drive_en, .default_auto_ack, .default_wait_states,
    .own_state, .bus_driven_out_n, .bus_request_out_n, .bus_drive_oe_n, .dram_addr_oe_n,
    .transfer_ack_out_n, .transfer_ack_oe_n, .chip_sel_n, .write_en_n, .row_strobe_n,
    .col_strobe_n, .dram_write_n, .core_may_start);
  twbo_far i_twbo_far (.mclk, .rst, .grant_want, .am_go, .am_addr, .am_read,
    .bus_driven_out_n, .transfer_ack_out_n, .transfer_ack_oe_n, .bus_grant_in_n,
    .transfer_start_in_n, .addr_in, .read_in, .xfer_width_code_in, .am_busy);
  always #50 mclk = ~mclk;
  // ----------------------------------------
  // checking helpers
  // ----------------------------------------
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic tick(int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : tick
  task automatic wait_own(twbo_own_e s);
    for (int i = 0; i < 8 && own_state !== s; i++) tick(1);
    chk("own_state", 32'(s), 32'(own_state));
  endtask : wait_own
  function automatic int exp_lat(int sp, int ws, logic aa);
    if (sp == 0) return 4;
    return aa ? 4 + ws : 12;
  endfunction : exp_lat
  task automatic summarize;
    $display("mismatches %0d comparisons %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : summarize
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      summarize();
    end
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    int n, sp, ws;
    logic top, aa;
    mclk = 0; rst = 1; watchdog_reset = 0; bus_lock_bit = 0; core_bus_need = 0;
    core_cycle_active = 0; core_cycle_end = 0; core_burst_inhibit_more = 0;
    grant_want = 0; am_go = 0; am_read = 0; am_addr = '0; top_addr_pins_are_addr = 1;
    cs_cfg = '0; dram_cfg = '0; dram_addr_drive_en = 0; default_auto_ack = 1;
    default_wait_states = TWBO_WS_ZERO;
    cs_cfg[0] = '{12'h000, 12'h00f, 1'b1, 1'b1, 1'b1, TWBO_WS_ZERO};
    dram_cfg[0] = '{12'h010, 12'h00f, 1'b1, 1'b1};
    dram_cfg[1] = '{12'h000, 12'hfff, 1'b0, 1'b0};
    void'($urandom(32'hf2ba));
    tick(20);
    chk("reset outputs", {2'(TWBO_RESET), 3'h7, 8'hff}, {own_state, bus_driven_out_n,
      bus_drive_oe_n, transfer_ack_oe_n, chip_sel_n});
    @(posedge mclk) rst <= 0;
    wait_own(TWBO_EM_OWN);
    @(posedge mclk) core_bus_need <= 1;
    tick(3);
    chk("bus_request_out_n", 0, bus_request_out_n);
    @(posedge mclk) grant_want <= 1;
    wait_own(TWBO_EXPL_OWN);
    chk("drive", 3'h1, {bus_driven_out_n, bus_drive_oe_n, core_may_start});
    @(posedge mclk) {core_bus_need, bus_lock_bit, grant_want} <= 3'b010;
    tick(6);
    chk("locked", 32'(TWBO_EXPL_OWN), 32'(own_state));
    @(posedge mclk) {bus_lock_bit, core_cycle_active} <= 2'b01;
    tick(5);
    chk("mid cycle", 32'(TWBO_EXPL_OWN), 32'(own_state));
    @(posedge mclk) {core_cycle_end, core_burst_inhibit_more} <= 2'b11;
    @(posedge mclk) core_cycle_end <= 0;
    tick(2);
    chk("inhibited burst", 32'(TWBO_EXPL_OWN), 32'(own_state));
    @(posedge mclk) {core_cycle_end, core_burst_inhibit_more} <= 2'b10;
    wait_own(TWBO_EM_OWN);
    chk("released", 3'h6, {bus_driven_out_n, bus_drive_oe_n, core_may_start});
    @(posedge mclk) {core_cycle_end, core_cycle_active, grant_want} <= 3'b001;
    wait_own(TWBO_IMPL_OWN);
    tick(4);
    chk("implicit", {2'(TWBO_IMPL_OWN), 2'b11}, {own_state, bus_driven_out_n,
      bus_drive_oe_n});
    @(posedge mclk) bus_lock_bit <= 1;
    wait_own(TWBO_EXPL_OWN);
    @(posedge mclk) bus_lock_bit <= 0;
    @(posedge mclk) watchdog_reset <= 1;
    @(posedge mclk) watchdog_reset <= 0;
    #1;
    chk("watchdog", 32'(TWBO_RESET), 32'(own_state));
    wait_own(TWBO_IMPL_OWN);
    @(posedge mclk) grant_want <= 0;
    wait_own(TWBO_EM_OWN);
    for (int t = 0; t < 12; t++) begin
      sp = t % 3;
      ws = $urandom % 4;
      top = 1'($urandom);
      aa = t != 11;
      @(posedge mclk);
      top_addr_pins_are_addr <= top;
      default_wait_states <= 4'(ws);
      default_auto_ack <= aa;
      dram_addr_drive_en <= 1'($urandom);
      am_read <= 1'($urandom);
      am_addr <= {top ? 4'h0 : 4'($urandom), 8'(sp * 16), 16'($urandom)};
      am_go <= 1;
      for (n = 0; n < 6 && transfer_start_in_n !== 1'b0; n++) tick(1);
      am_go <= 0;
      for (n = 0; n < 12 && {transfer_ack_out_n, transfer_ack_oe_n} !== 2'b00; n++) tick(1);
      if (sp == 1) chk("dram", {1'b1, 2'b00, am_read, !dram_addr_drive_en}, {n == 4,
        row_strobe_n[0], &col_strobe_n, dram_write_n, dram_addr_oe_n});
      else chk("ack delay", exp_lat(sp, ws, aa), n);
      if (sp == 0) chk("select", {1'b0, am_read}, {chip_sel_n[0], &write_en_n});
      if (sp == 2) chk("default", 3'h7, {&chip_sel_n, &row_strobe_n, dram_addr_oe_n});
      for (n = 0; n < 20 && am_busy !== 1'b0; n++) tick(1);
      tick(3);
    end
    summarize();
  end
endmodule : tb
bind twbo_arbiter twbo_props i_twbo_props (.mclk, .rst, .watchdog_reset, .bus_grant_in_n,
  .bus_lock_bit, .core_bus_need, .core_cycle_active, .core_cycle_end,
  .core_burst_inhibit_more, .dram_addr_drive_en, .own_state, .bus_driven_out_n,
  .bus_request_out_n, .bus_drive_oe_n, .dram_addr_oe_n, .transfer_ack_out_n,
  .transfer_ack_oe_n, .chip_sel_n, .core_may_start);
`default_nettype wire

//--- verification/twbo_far.sv
// far side: external arbiter and one alternate bus master
`default_nettype none
module twbo_far
  import twbo_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic grant_want,
  input wire logic am_go,
  input wire logic [TWBO_AW-1:0] am_addr,
  input wire logic am_read,
  input wire logic bus_driven_out_n,
  input wire logic transfer_ack_out_n,
  input wire logic transfer_ack_oe_n,
  output logic bus_grant_in_n,
  output logic transfer_start_in_n,
  output logic [TWBO_AW-1:0] addr_in,
  output logic read_in,
  output logic [1:0] xfer_width_code_in,
  output logic am_busy
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] age;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      bus_grant_in_n <= 1'b1;
      transfer_start_in_n <= 1'b1;
      addr_in <= '0;
      read_in <= 1'b1;
      xfer_width_code_in <= 2'h0;
      am_busy <= 1'b0;
      age <= 4'h0;
    end else begin
      // grant only while the alternate master is idle
      bus_grant_in_n <= !(grant_want && !am_busy && !am_go);
      transfer_start_in_n <= 1'b1;
      if (am_busy) begin
        age <= age + 4'h1;
        if ((!transfer_ack_out_n && !transfer_ack_oe_n) || age == 4'hf) begin
          am_busy <= 1'b0;
          // released lines no longer show the last value
          addr_in <= ~addr_in;
          read_in <= ~read_in;
        end
      end else if (am_go && bus_grant_in_n && bus_driven_out_n) begin
        am_busy <= 1'b1;
        age <= 4'h0;
        transfer_start_in_n <= 1'b0;
        addr_in <= {am_addr[TWBO_AW-1:2], 2'h0};
        read_in <= am_read;
        xfer_width_code_in <= 2'h0;
      end
    end
  end
endmodule : twbo_far
`default_nettype wire

//--- verification/twbo_props.sv
// checker: ownership and acknowledge relations at the arbiter ports
`default_nettype none
module twbo_props
  import twbo_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic watchdog_reset,
  input wire logic bus_grant_in_n,
  input wire logic bus_lock_bit,
  input wire logic core_bus_need,
  input wire logic core_cycle_active,
  input wire logic core_cycle_end,
  input wire logic core_burst_inhibit_more,
  input wire logic dram_addr_drive_en,
  input wire twbo_own_e own_state,
  input wire logic bus_driven_out_n,
  input wire logic bus_request_out_n,
  input wire logic bus_drive_oe_n,
  input wire logic dram_addr_oe_n,
  input wire logic transfer_ack_out_n,
  input wire logic transfer_ack_oe_n,
  input wire logic [TWBO_NCS-1:0] chip_sel_n,
  input wire logic core_may_start
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------
  // grant pin history, past the synchroniser
  // ----------------------------------------
  logic [2:0] gh;
  logic hi, lo, ex, ie, nw, fin;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) gh <= 3'h5;
    else gh <= {gh[1:0], bus_grant_in_n};
  end
  assign hi = &{gh, bus_grant_in_n};
  assign lo = ~|{gh, bus_grant_in_n};
  assign ex = own_state == TWBO_EXPL_OWN;
  assign ie = own_state inside {TWBO_IMPL_OWN, TWBO_EM_OWN};
  assign nw = !watchdog_reset;
  assign fin = !core_cycle_active || (core_cycle_end && !core_burst_inhibit_more);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  sequence s_ack_tail;
    (transfer_ack_out_n && !transfer_ack_oe_n) ##1 transfer_ack_oe_n;
  endsequence
  property p_wdog; watchdog_reset |=> own_state == TWBO_RESET && bus_driven_out_n; endproperty
  property p_exit; own_state == TWBO_RESET && nw |=> ie; endproperty
  property p_bd; (ex == !bus_driven_out_n) && (bus_drive_oe_n == bus_driven_out_n); endproperty
  property p_impl;
    own_state == TWBO_IMPL_OWN && lo && !bus_lock_bit && !core_bus_need && nw
      |=> own_state == TWBO_IMPL_OWN;
  endproperty
  property p_go; ie && lo && (bus_lock_bit || core_bus_need) && nw |=> ex; endproperty
  property p_neg; ie && hi && nw |=> own_state == TWBO_EM_OWN; endproperty
  property p_lock; ex && bus_lock_bit && nw |=> ex; endproperty
  property p_hold; ex && !fin && nw |=> ex; endproperty
  property p_rel;
    ex && hi && !bus_lock_bit && fin && nw |=> own_state == TWBO_EM_OWN && bus_drive_oe_n;
  endproperty
  property p_req; !bus_driven_out_n |=> $stable(bus_request_out_n); endproperty
  property p_reqv; hi && bus_driven_out_n |=> bus_request_out_n == !$past(core_bus_need); endproperty
  property p_ack; $fell(transfer_ack_out_n) |-> !transfer_ack_oe_n ##1 s_ack_tail; endproperty
  property p_may; core_may_start |-> ex; endproperty
  property p_dra; !dram_addr_oe_n |-> dram_addr_drive_en && (&chip_sel_n); endproperty
  a_wdog: assert property (p_wdog) else $error("watchdog did not reset ownership");
  a_exit: assert property (p_exit) else $error("bad state after reset");
  a_bd: assert property (p_bd) else $error("bus driven does not match state");
  a_impl: assert property (p_impl) else $error("implicit ownership left");
  a_go: assert property (p_go) else $error("explicit ownership not taken");
  a_neg: assert property (p_neg) else $error("no external ownership on negated grant");
  a_lock: assert property (p_lock) else $error("locked ownership dropped");
  a_hold: assert property (p_hold) else $error("bus released mid cycle");
  a_rel: assert property (p_rel) else $error("bus not released at cycle end");
  a_req: assert property (p_req) else $error("request changed while driving");
  a_reqv: assert property (p_reqv) else $error("request not a copy of core need");
  a_ack: assert property (p_ack) else $error("acknowledge tail wrong");
  a_may: assert property (p_may) else $error("core start outside explicit");
  a_dra: assert property (p_dra) else $error("address driven wrongly");
endmodule : twbo_props
`default_nettype wire

//--- verilog/twbo_arbiter.sv
// bus ownership state machine with alternate-master memory control
`default_nettype none
module twbo_arbiter
  import twbo_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic watchdog_reset,
  input wire logic bus_grant_in_n,
  input wire logic bus_lock_bit,
  input wire logic core_bus_need,
  input wire logic core_cycle_active,
  input wire logic core_cycle_end,
  input wire logic core_burst_inhibit_more,
  input wire logic transfer_start_in_n,
  input wire logic [TWBO_AW-1:0] addr_in,
  input wire logic read_in,
  input wire logic [1:0] xfer_width_code_in,
  input wire logic top_addr_pins_are_addr,
  input wire twbo_cs_s [TWBO_NCS-1:0] cs_cfg,
  input wire twbo_dram_s [TWBO_NRAS-1:0] dram_cfg,
  input wire logic dram_addr_drive_en,
  input wire logic default_auto_ack,
  input wire logic [TWBO_WSW-1:0] default_wait_states,
  output twbo_own_e own_state,
  output logic bus_driven_out_n,
  output logic bus_request_out_n,
  output logic bus_drive_oe_n,
  output logic dram_addr_oe_n,
  output logic transfer_ack_out_n,
  output logic transfer_ack_oe_n,
  output logic [TWBO_NCS-1:0] chip_sel_n,
  output logic [TWBO_NWE-1:0] write_en_n,
  output logic [TWBO_NRAS-1:0] row_strobe_n,
  output logic [TWBO_NCAS-1:0] col_strobe_n,
  output logic dram_write_n,
  output logic core_may_start
);
  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  logic grant_n_s;
  logic ts_n_s;

  twbo_sync #(.W(2)) u_sync (
    .mclk(mclk),
    .rst(rst),
    .d({bus_grant_in_n, transfer_start_in_n}),
    .q({grant_n_s, ts_n_s})
  );

  logic granted;
  assign granted = !grant_n_s;

  // ------------------------------------------------------------
  // ownership state machine
  // ------------------------------------------------------------
  twbo_own_e next_own_state;
  logic next_bus_driven_out_n;
  logic next_bus_drive_oe_n;
  logic next_bus_request_out_n;
  logic next_core_may_start;
  logic cycle_done;

  // a burst-inhibited series only ends at its last transfer
  assign cycle_done = core_cycle_end && !core_burst_inhibit_more;

  always_comb begin
    next_own_state = own_state;
    if (watchdog_reset) begin
      next_own_state = TWBO_RESET;
    end else begin
      unique case (own_state)
        TWBO_RESET: begin
          next_own_state = granted ? TWBO_IMPL_OWN : TWBO_EM_OWN;
        end
        TWBO_IMPL_OWN, TWBO_EM_OWN: begin
          if (!granted) begin
            next_own_state = TWBO_EM_OWN;
          end else if (core_bus_need || bus_lock_bit) begin
            next_own_state = TWBO_EXPL_OWN;
          end else begin
            next_own_state = TWBO_IMPL_OWN;
          end
        end
        TWBO_EXPL_OWN: begin
          if (granted || bus_lock_bit) begin
            next_own_state = TWBO_EXPL_OWN;
          end else if (!core_cycle_active || cycle_done) begin
            next_own_state = TWBO_EM_OWN;
          end
        end
      endcase
    end
    // outputs follow the next state so they are flops of it
    next_bus_driven_out_n = (next_own_state != TWBO_EXPL_OWN);
    next_bus_drive_oe_n = (next_own_state != TWBO_EXPL_OWN);
    // registered copy of the core request only while granted and driven both negated
    next_bus_request_out_n = bus_request_out_n;
    if (!granted && bus_driven_out_n) begin
      next_bus_request_out_n = !core_bus_need;
    end
    // one cycle after grant the core may launch a transfer
    next_core_may_start = (next_own_state == TWBO_EXPL_OWN) && granted;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      own_state <= TWBO_RESET;
      bus_driven_out_n <= 1'b1;
      bus_drive_oe_n <= 1'b1;
      bus_request_out_n <= 1'b1;
      core_may_start <= 1'b0;
    end else begin
      own_state <= next_own_state;
      bus_driven_out_n <= next_bus_driven_out_n;
      bus_drive_oe_n <= next_bus_drive_oe_n;
      bus_request_out_n <= next_bus_request_out_n;
      core_may_start <= next_core_may_start;
    end
  end

  // ------------------------------------------------------------
  // alternate master capture and decode
  // ------------------------------------------------------------
  twbo_cap_s cap;
  twbo_cap_s next_cap;
  twbo_dec_s dec;
  twbo_am_e am_state;
  twbo_am_e next_am_state;
  logic [TWBO_WSW-1:0] ws_cnt;
  logic [TWBO_WSW-1:0] next_ws_cnt;
  logic am_start;

  // watch only while the device is not driving
  assign am_start = !ts_n_s && bus_driven_out_n && am_state == TWBO_AM_IDLE;

  always_comb begin
    next_cap = cap;
    if (am_start) begin
      next_cap.addr = addr_in;
      next_cap.read = read_in;
      next_cap.xfer_width_code = xfer_width_code_in;
      if (!top_addr_pins_are_addr) begin
        next_cap.addr[TWBO_AW-1:TWBO_TOP_LSB] = TWBO_TOP_ZERO;
      end
    end
  end

  twbo_decode u_decode (
    .cap(cap),
    .cs_cfg(cs_cfg),
    .dram_cfg(dram_cfg),
    .dec(dec)
  );

  // ------------------------------------------------------------
  // memory control and acknowledge sequencing
  // ------------------------------------------------------------
  logic ack_en;
  logic next_ack_en;
  logic next_transfer_ack_out_n;
  logic next_transfer_ack_oe_n;
  logic next_dram_addr_oe_n;
  logic [TWBO_NCS-1:0] next_chip_sel_n;
  logic [TWBO_NWE-1:0] next_write_en_n;
  logic [TWBO_NRAS-1:0] next_row_strobe_n;
  logic [TWBO_NCAS-1:0] next_col_strobe_n;
  logic next_dram_write_n;

  always_comb begin
    next_am_state = am_state;
    next_ws_cnt = ws_cnt;
    next_ack_en = ack_en;
    next_transfer_ack_out_n = transfer_ack_out_n;
    next_transfer_ack_oe_n = transfer_ack_oe_n;
    next_dram_addr_oe_n = dram_addr_oe_n;
    next_chip_sel_n = chip_sel_n;
    next_write_en_n = write_en_n;
    next_row_strobe_n = row_strobe_n;
    next_col_strobe_n = col_strobe_n;
    next_dram_write_n = dram_write_n;
    unique case (am_state)
      TWBO_AM_IDLE: begin
        next_transfer_ack_oe_n = 1'b1;
        next_transfer_ack_out_n = 1'b1;
        if (am_start) begin
          next_am_state = TWBO_AM_DECODE;
        end
      end
      TWBO_AM_DECODE: begin
        // decode cycle: start memory control on the next edge
        next_am_state = TWBO_AM_WAIT;
        next_ack_en = 1'b0;
        next_ws_cnt = TWBO_WS_ZERO;
        if (dec.cs_hit) begin
          next_chip_sel_n = ~dec.cs_sel;
          next_write_en_n = (|dec.cs_sel && !cap.read) ? '0 : '1;
          next_ack_en = dec.cs_ack && |dec.cs_sel;
          next_ws_cnt = dec.cs_ws;
        end else if (dec.dram_hit) begin
          next_row_strobe_n = ~dec.ras_sel;
          next_col_strobe_n = |dec.ras_sel ? '0 : '1;
          next_dram_write_n = !(|dec.ras_sel && !cap.read);
          next_ack_en = |dec.ras_sel;
          next_dram_addr_oe_n = !dram_addr_drive_en;
        end else begin
          next_ack_en = default_auto_ack;
          next_ws_cnt = default_wait_states;
        end
        if (next_ack_en) begin
          next_transfer_ack_oe_n = 1'b0;
          next_transfer_ack_out_n = (next_ws_cnt != TWBO_WS_ZERO);
        end
        if (!next_ack_en || next_ws_cnt == TWBO_WS_ZERO) begin
          next_am_state = next_ack_en ? TWBO_AM_NEGATE : TWBO_AM_WAIT;
        end
      end
      TWBO_AM_WAIT: begin
        if (ack_en) begin
          next_ws_cnt = ws_cnt - TWBO_WS_ONE;
          if (ws_cnt == TWBO_WS_ONE) begin
            next_transfer_ack_out_n = 1'b0;
            next_am_state = TWBO_AM_NEGATE;
          end
        end else if (!ts_n_s) begin
          // no acknowledge of ours: a start seen here returns to idle, otherwise negate follows
          next_am_state = TWBO_AM_IDLE;
        end
        if (!ack_en && ts_n_s) begin
          next_am_state = TWBO_AM_NEGATE;
        end
      end
      TWBO_AM_NEGATE: begin
        next_transfer_ack_out_n = 1'b1;
        next_chip_sel_n = '1;
        next_write_en_n = '1;
        next_row_strobe_n = '1;
        next_col_strobe_n = '1;
        next_dram_write_n = 1'b1;
        next_dram_addr_oe_n = 1'b1;
        next_am_state = TWBO_AM_IDLE;
      end
    endcase
    if (!bus_driven_out_n) begin
      next_am_state = TWBO_AM_IDLE;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      am_state <= TWBO_AM_IDLE;
      cap <= '0;
      ws_cnt <= TWBO_WS_ZERO;
      ack_en <= 1'b0;
      transfer_ack_out_n <= 1'b1;
      transfer_ack_oe_n <= 1'b1;
      dram_addr_oe_n <= 1'b1;
      chip_sel_n <= '1;
      write_en_n <= '1;
      row_strobe_n <= '1;
      col_strobe_n <= '1;
      dram_write_n <= 1'b1;
    end else begin
      am_state <= next_am_state;
      cap <= next_cap;
      ws_cnt <= next_ws_cnt;
      ack_en <= next_ack_en;
      transfer_ack_out_n <= next_transfer_ack_out_n;
      transfer_ack_oe_n <= next_transfer_ack_oe_n;
      dram_addr_oe_n <= next_dram_addr_oe_n;
      chip_sel_n <= next_chip_sel_n;
      write_en_n <= next_write_en_n;
      row_strobe_n <= next_row_strobe_n;
      col_strobe_n <= next_col_strobe_n;
      dram_write_n <= next_dram_write_n;
    end
  end
endmodule : twbo_arbiter
`default_nettype wire

//--- verilog/twbo_decode.sv
// address decoder for alternate-master transfers
`default_nettype none
module twbo_decode
  import twbo_pkg::*;
(
  input wire twbo_cap_s cap,
  input wire twbo_cs_s [TWBO_NCS-1:0] cs_cfg,
  input wire twbo_dram_s [TWBO_NRAS-1:0] dram_cfg,
  output twbo_dec_s dec
);
  function automatic logic dir_ok(input logic rd, input logic rd_en, input logic wr_en);
    dir_ok = rd ? rd_en : wr_en;
  endfunction : dir_ok

  always_comb begin
    dec = '0;
    // attribute and transfer-type inputs are not part of the match
    for (int i = TWBO_NCS - 1; i >= 0; i--) begin
      if (((cap.addr[TWBO_AW-1:TWBO_CS_LSB] ^ cs_cfg[i].base) & ~cs_cfg[i].mask) == '0) begin
        dec.cs_hit = 1'b1;
        dec.cs_sel = '0;
        if (dir_ok(cap.read, cs_cfg[i].rd_en, cs_cfg[i].wr_en)) begin
          dec.cs_sel[i] = 1'b1;
        end
        dec.cs_ack = cs_cfg[i].alt_master_auto_ack;
        dec.cs_ws = cs_cfg[i].wait_state_count;
      end
    end
    for (int j = TWBO_NRAS - 1; j >= 0; j--) begin
      if (!dec.cs_hit && dram_cfg[j].mask != '1 &&
          ((cap.addr[TWBO_AW-1:TWBO_DRAM_LSB] ^ dram_cfg[j].base) & ~dram_cfg[j].mask) == '0)
      begin
        dec.dram_hit = 1'b1;
        dec.ras_sel = '0;
        if (dir_ok(cap.read, dram_cfg[j].rd_en, dram_cfg[j].wr_en)) begin
          dec.ras_sel[j] = 1'b1;
        end
      end
    end
  end
endmodule : twbo_decode
`default_nettype wire

//--- verilog/twbo_pkg.sv
// package: states, carriers and constants of the three-wire bus ownership block
`default_nettype none
package twbo_pkg;
  localparam int TWBO_AW = 28;
  localparam int TWBO_NCS = 8;
  localparam int TWBO_NWE = 4;
  localparam int TWBO_NRAS = 2;
  localparam int TWBO_NCAS = 4;
  localparam int TWBO_WSW = 4;
  localparam int TWBO_TOP_LSB = 24;
  localparam logic [3:0] TWBO_TOP_ZERO = 4'h0;
  localparam logic [TWBO_WSW-1:0] TWBO_WS_ZERO = 4'h0;
  localparam logic [TWBO_WSW-1:0] TWBO_WS_ONE = 4'h1;
  // dram banks decode on address bits 27:16
  localparam int TWBO_DRAM_LSB = 16;
  localparam int TWBO_CS_LSB = 16;

  // gray codes along reset -> em -> implicit -> explicit
  typedef enum logic [1:0] {
    TWBO_RESET = 2'h0,
    TWBO_EM_OWN = 2'h1,
    TWBO_IMPL_OWN = 2'h3,
    TWBO_EXPL_OWN = 2'h2
  } twbo_own_e;

  typedef enum logic [1:0] {
    TWBO_AM_IDLE = 2'h0,
    TWBO_AM_DECODE = 2'h1,
    TWBO_AM_WAIT = 2'h3,
    TWBO_AM_NEGATE = 2'h2
  } twbo_am_e;

  typedef struct packed {
    logic [TWBO_AW-1:0] addr;
    logic read;
    logic [1:0] xfer_width_code;
  } twbo_cap_s;

  // one chip-select window
  typedef struct packed {
    logic [TWBO_AW-1:TWBO_CS_LSB] base;
    logic [TWBO_AW-1:TWBO_CS_LSB] mask;
    logic rd_en;
    logic wr_en;
    logic alt_master_auto_ack;
    logic [TWBO_WSW-1:0] wait_state_count;
  } twbo_cs_s;

  // one dram bank window
  typedef struct packed {
    logic [TWBO_AW-1:TWBO_DRAM_LSB] base;
    logic [TWBO_AW-1:TWBO_DRAM_LSB] mask;
    logic rd_en;
    logic wr_en;
  } twbo_dram_s;

  typedef struct packed {
    logic cs_hit;
    logic [TWBO_NCS-1:0] cs_sel;
    logic cs_ack;
    logic [TWBO_WSW-1:0] cs_ws;
    logic dram_hit;
    logic [TWBO_NRAS-1:0] ras_sel;
  } twbo_dec_s;
endpackage : twbo_pkg
`default_nettype wire

//--- verilog/twbo_sync.sv
// two-flop synchroniser for pin inputs
`default_nettype none
module twbo_sync
  import twbo_pkg::*;
#(
  parameter int W = 1
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;
  logic [W-1:0] next_meta;
  logic [W-1:0] next_q;

  always_comb begin
    next_meta = d;
    next_q = meta;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= next_meta;
      q <= next_q;
    end
  end
endmodule : twbo_sync
`default_nettype wire
